// ==== include/adc_seq_defs.vh ====
/*
  constants for the conversion sequencer: register offsets,
  field positions, reset values and phase lengths.
  assumes a 25 MHz peripheral clock and a 16-bit register port.
*/
`ifndef ADC_SEQ_DEFS_VH
`define ADC_SEQ_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADC_OFS_CTRL 8'h00
`define ADC_OFS_CHSEL 8'h04
`define ADC_OFS_RES_FULL 8'h08
`define ADC_OFS_RES_UPPER 8'h0C
`define ADC_OFS_STATUS 8'h10

// ----------------------------------------
// control fields
// ----------------------------------------
`define ADC_CTRL_ENABLE 0
`define ADC_CTRL_START 1
`define ADC_CTRL_ONESHOT 2
`define ADC_CTRL_SCAN 3
`define ADC_CTRL_HWTRIG 4

// ----------------------------------------
// reset values and phase lengths
// ----------------------------------------
`define ADC_CHSEL_RST 5'h00
`define ADC_RES_RST 16'h0000
`define ADC_SCAN_SLOTS 4
`define ADC_SAMPLE_CYC 8
`define ADC_CMP_CYC 4
`define ADC_STAB_NS 1000
`define ADC_CLK_NS 40
`define ADC_STAB_CYC ((`ADC_STAB_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)

`endif

// ==== verif/adc_seq_sva.sv ====
/*
  port checker for the conversion sequencer.
  assumes the register map of adc_seq_defs.vh.
*/
`timescale 1ns/100ps
`include "adc_seq_defs.vh"
module adc_seq_sva (
  input wire mclk_i,
  input wire rstn_i,
  input wire [7:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire hw_trig_i,
  input wire [4:0] channel_o,
  input wire sample_o,
  input wire powered_o,
  input wire busy_o,
  input wire conv_end_interrupt_o
);
  // ----
  // shadow of mode bits; start kept loose, so it only widens
  // ----
  reg hw_q;
  reg st_q;
  wire cw = wr_i && addr_i == `ADC_OFS_CTRL;
  wire sw = wr_i && addr_i == `ADC_OFS_CHSEL;
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hw_q <= 1'b0;
      st_q <= 1'b0;
    end else if (cw) begin
      hw_q <= wdata_i[`ADC_CTRL_HWTRIG];
      st_q <= wdata_i[1] & wdata_i[0];
    end
  end
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  // ----
  // properties
  // ----
  property p_irq; conv_end_interrupt_o |=> !conv_end_interrupt_o; endproperty
  property p_irqb; conv_end_interrupt_o |-> $past(busy_o); endproperty
  property p_launch; $rose(busy_o) |-> sample_o && powered_o; endproperty
  property p_off; !powered_o && $past(!powered_o) |-> !busy_o; endproperty
  property p_ign; !busy_o && hw_trig_i && !wr_i && !(hw_q && st_q) |=> !busy_o; endproperty
  property p_arm; cw && wdata_i[4] && !busy_o |=> !busy_o; endproperty
  property p_stop; cw && !wdata_i[1] |=> !busy_o; endproperty
  property p_pow; cw && wdata_i[0] |-> ##[1:2] powered_o; endproperty
  property p_abort; busy_o && (cw || sw || hw_q && hw_trig_i) |=> !conv_end_interrupt_o; endproperty
  property p_chsel; busy_o && sw |=> sample_o && channel_o == $past(wdata_i[4:0]); endproperty
  property p_rest; busy_o && cw && wdata_i[1:0] == 2'b11 |=> busy_o && sample_o; endproperty
  a_irq: assert property (p_irq) else $error("end pulse too long");
  a_irqb: assert property (p_irqb) else $error("end pulse without conversion");
  a_launch: assert property (p_launch) else $error("launch without sampling");
  a_off: assert property (p_off) else $error("conversion while disabled");
  a_ign: assert property (p_ign) else $error("trigger started conversion");
  a_arm: assert property (p_arm) else $error("arming started conversion");
  a_stop: assert property (p_stop) else $error("start clear kept busy");
  a_pow: assert property (p_pow) else $error("converter not powered");
  a_abort: assert property (p_abort) else $error("aborted conversion stored");
  a_chsel: assert property (p_chsel) else $error("channel write no restart");
  a_rest: assert property (p_rest) else $error("start rewrite no restart");
  c_irq: cover property (conv_end_interrupt_o);
  c_rest: cover property (busy_o && cw && wdata_i[1]);
  c_hw: cover property (hw_q && st_q && hw_trig_i && !busy_o);
endmodule // adc_seq_sva
bind adc_conversion_sequencer adc_seq_sva chk_u (.mclk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .hw_trig_i,
  .channel_o, .sample_o, .powered_o, .busy_o, .conv_end_interrupt_o);

// ==== verif/analog_model.sv ====
/*
  comparator stand-in for the analog inputs.
  assumes each channel holds the fixed level {channel, 5'h0D}.
*/
`timescale 1ns/100ps
module analog_model (
  input wire [9:0] sar_code_i,
  input wire [4:0] channel_i,
  output wire comp_o
);
  // ----
  // level per channel, so a result names its channel
  // ----
  assign comp_o = {channel_i, 5'h0D} >= sar_code_i;
endmodule // analog_model

// ==== verif/tb_top.sv ====
/*
  bench for the conversion sequencer.
  assumes default phase lengths and the analog_model comparator.
*/
`timescale 1ns/100ps
`include "adc_seq_defs.vh"
module tb_top;
  reg mclk_i = 1'b0;
  reg rstn_i = 1'b0;
  reg [7:0] addr_i = 8'h00;
  reg [15:0] wdata_i = 16'h0000;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg hw_trig_i = 1'b0;
  wire [15:0] rdata_o;
  wire comp_i;
  wire [9:0] sar_code_o;
  wire [4:0] channel_o;
  wire sample_o;
  wire powered_o;
  wire busy_o;
  wire conv_end_interrupt_o;
  integer error_cnt = 0;
  integer n_checks = 0;
  integer w;
  reg [15:0] v;
  always #20 mclk_i = ~mclk_i;
  adc_conversion_sequencer dut (.mclk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .hw_trig_i,
    .comp_i, .sar_code_o, .channel_o, .sample_o, .powered_o, .busy_o, .conv_end_interrupt_o);
  analog_model am (.sar_code_i(sar_code_o), .channel_i(channel_o), .comp_o(comp_i));
  // ----
  // bus, trigger and compare helpers
  // ----
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task chk(input [15:0] g, input [15:0] e);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      @(negedge mclk_i);
      v = rdata_o;
    end
  endtask
  task trig;
    begin
      @(posedge mclk_i);
      hw_trig_i <= 1'b1;
      @(posedge mclk_i);
      hw_trig_i <= 1'b0;
    end
  endtask
  // bounded: a lost end pulse ends the run
  task wirq;
    begin
      w = 0;
      @(negedge mclk_i);
      for (w = 0; w < 200 && conv_end_interrupt_o !== 1'b1; w = w + 1)
        @(negedge mclk_i);
      if (w == 200) begin
        error_cnt = error_cnt + 1;
        give_verdict;
      end else begin
        @(negedge mclk_i);
      end
    end
  endtask
  task quiet;
    integer i;
    integer b;
    begin
      b = 0;
      for (i = 0; i < 60; i = i + 1) begin
        @(negedge mclk_i);
        b = b | busy_o | conv_end_interrupt_o;
      end
      chk(b, 16'h0);
    end
  endtask
  task cres(input [4:0] c);
    reg [9:0] e;
    begin
      e = {c, 5'h0D};
      rd(`ADC_OFS_RES_FULL);
      chk(v, {e, 6'h00});
      rd(`ADC_OFS_RES_UPPER);
      chk(v, {8'h00, e[9:2]});
    end
  endtask
  // ----
  // scenarios
  // ----
  task t_reg;
    begin
      rd(`ADC_OFS_CTRL);
      chk(v, 16'h0);
      rd(`ADC_OFS_CHSEL);
      chk(v, `ADC_CHSEL_RST);
      rd(`ADC_OFS_RES_FULL);
      chk(v, `ADC_RES_RST);
      rd(8'h14);
      chk(v, 16'h0);
      $display("test reg done");
    end
  endtask
  task t_enable;
    begin
      wr(`ADC_OFS_CTRL, 16'h0002);
      quiet;
      wr(`ADC_OFS_CTRL, 16'h0001);
      repeat (`ADC_STAB_CYC) @(posedge mclk_i);
      rd(`ADC_OFS_STATUS);
      chk(v[3:2], 16'h1);
      chk(powered_o, 16'h1);
      $display("test enable done");
    end
  endtask
  task t_scan_one;
    integer k;
    begin
      wr(`ADC_OFS_CHSEL, 16'h0004);
      wr(`ADC_OFS_CTRL, 16'h000F);
      trig;
      for (k = 0; k < 4; k = k + 1) begin
        wirq;
        cres(4 + k);
      end
      quiet;
      rd(`ADC_OFS_CTRL);
      chk(v[1], 16'h0);
      trig;
      quiet;
      $display("test scan one-shot done");
    end
  endtask
  task t_scan_seq;
    begin
      wr(`ADC_OFS_CHSEL, 16'h0008);
      wr(`ADC_OFS_CTRL, 16'h000B);
      repeat (5) wirq;
      cres(8);
      repeat (20) @(posedge mclk_i);
      wr(`ADC_OFS_CTRL, 16'h000B);
      wirq;
      cres(8);
      repeat (20) @(posedge mclk_i);
      wr(`ADC_OFS_CHSEL, 16'h0010);
      wirq;
      cres(16);
      repeat (20) @(posedge mclk_i);
      wr(`ADC_OFS_CTRL, 16'h0009);
      quiet;
      rd(`ADC_OFS_STATUS);
      chk(v[3:2], 16'h1);
      $display("test scan sequential done");
    end
  endtask
  task t_hw;
    begin
      wr(`ADC_OFS_CHSEL, 16'h0003);
      wr(`ADC_OFS_CTRL, 16'h0013);
      quiet;
      rd(`ADC_OFS_STATUS);
      chk(v[3:2], 16'h2);
      trig;
      wirq;
      cres(3);
      wirq;
      cres(3);
      repeat (20) @(posedge mclk_i);
      trig;
      wirq;
      chk(w > 40, 16'h1);
      // write lands on the very edge that would complete
      repeat (`ADC_SAMPLE_CYC + 10 * `ADC_CMP_CYC - 3) @(posedge mclk_i);
      wr(`ADC_OFS_CTRL, 16'h0013);
      wirq;
      chk(w > 40, 16'h1);
      repeat (20) @(posedge mclk_i);
      wr(`ADC_OFS_CHSEL, 16'h0005);
      wirq;
      cres(5);
      repeat (20) @(posedge mclk_i);
      wr(`ADC_OFS_CTRL, 16'h0017);
      wirq;
      chk(w > 40, 16'h1);
      quiet;
      rd(`ADC_OFS_CTRL);
      chk(v[1], 16'h1);
      trig;
      wirq;
      cres(5);
      trig;
      repeat (20) @(posedge mclk_i);
      wr(`ADC_OFS_CTRL, 16'h0015);
      quiet;
      chk(powered_o, 16'h1);
      trig;
      quiet;
      wr(`ADC_OFS_CTRL, 16'h0000);
      repeat (3) @(posedge mclk_i);
      chk(powered_o, 16'h0);
      $display("test hardware trigger done");
    end
  endtask
  initial begin
    repeat (10) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_reg;
    t_enable;
    t_scan_one;
    t_scan_seq;
    wr(`ADC_OFS_CTRL, 16'h0001);
    t_hw;
    give_verdict;
  end
endmodule // tb_top

// ==== verilog/adc_conversion_sequencer.v ====
/*
  conversion sequencer for a successive-approximation converter:
  software-trigger and hardware-trigger no-wait modes, scan or select in each.
  assumes the analog comparator output is asynchronous and the
  hardware trigger is a one-cycle pulse on mclk_i.
*/
`timescale 1ns/100ps
`include "adc_seq_defs.vh"

module adc_conversion_sequencer #(
  parameter SAMPLE_CYC = `ADC_SAMPLE_CYC,
  parameter CMP_CYC = `ADC_CMP_CYC
) (
  input wire mclk_i,
  input wire rstn_i,
  input wire [7:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  input wire hw_trig_i,
  input wire comp_i,
  output reg [9:0] sar_code_o,
  output reg [4:0] channel_o,
  output reg sample_o,
  output reg powered_o,
  output reg busy_o,
  output reg conv_end_interrupt_o
);

  // ----------------------------------------
  // states and phase loads
  // ----------------------------------------
  localparam [1:0] ST_STOP = 2'h0;
  localparam [1:0] ST_STBY = 2'h1;
  localparam [1:0] ST_HWSTBY = 2'h2;
  localparam [1:0] ST_CONV = 2'h3;
  localparam integer SAMP_INT = SAMPLE_CYC - 1;
  localparam integer CMP_INT = CMP_CYC - 1;
  localparam integer SLOT_INT = `ADC_SCAN_SLOTS - 1;
  localparam [7:0] SAMP_LD = SAMP_INT[7:0];
  localparam [7:0] CMP_LD = CMP_INT[7:0];
  localparam [1:0] LAST_SLOT = SLOT_INT[1:0];

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg enable_q;
  reg enable_d;
  reg start_q;
  reg start_d;
  reg oneshot_q;
  reg oneshot_d;
  reg scan_q;
  reg scan_d;
  reg hwmode_q;
  reg hwmode_d;
  reg [4:0] chsel_q;
  reg [4:0] chsel_d;
  reg [1:0] idx_q;
  reg [1:0] idx_d;
  reg [15:0] res_full_q;
  reg [7:0] res_upper_q;
  reg [7:0] cnt_q;
  reg [3:0] bit_q;
  reg comp_meta_q;
  reg comp_s_q;
  reg launch;
  reg store;
  reg restart;
  reg irq_d;
  reg [15:0] rdata_d;

  wire wr_ctrl;
  wire wr_chsel;
  wire in_conv;
  wire done_w;
  wire [9:0] bit_mask;
  wire [9:0] sar_final;
  wire [4:0] chan_next;
  wire wr_enable;
  wire wr_start;
  wire wr_oneshot;
  wire wr_scan;
  wire wr_hwmode;
  wire abort_start;
  wire abort_chsel;
  wire abort_trig;
  wire cmp_last;
  wire [15:0] ctrl_word;
  wire [15:0] chsel_word;
  wire [15:0] status_word;
  wire [9:0] sar_step;

  assign wr_ctrl = wr_i && (addr_i == `ADC_OFS_CTRL);
  assign wr_chsel = wr_i && (addr_i == `ADC_OFS_CHSEL);
  assign in_conv = (state_q == ST_CONV);
  assign cmp_last = in_conv && !sample_o && (cnt_q == 8'h00);
  assign done_w = cmp_last && (bit_q == 4'h0);
  assign bit_mask = 10'h001 << bit_q;
  // the last trial bit is decided in the same cycle as completion
  assign sar_final = comp_s_q ? sar_code_o : (sar_code_o & ~bit_mask);
  assign chan_next = chsel_d + {3'h0, idx_d};

  // ----------------------------------------
  // write fields and abort causes
  // ----------------------------------------
  assign wr_enable = wdata_i[`ADC_CTRL_ENABLE];
  assign wr_start = wdata_i[`ADC_CTRL_START];
  assign wr_oneshot = wdata_i[`ADC_CTRL_ONESHOT];
  assign wr_scan = wdata_i[`ADC_CTRL_SCAN];
  assign wr_hwmode = wdata_i[`ADC_CTRL_HWTRIG];
  // a start rewrite only counts while a conversion really runs
  assign abort_start = wr_ctrl && in_conv && enable_q && start_q && wr_start;
  assign abort_chsel = wr_chsel && in_conv;
  // software modes never react to the trigger
  assign abort_trig = hw_trig_i && in_conv && hwmode_q;

  // ----------------------------------------
  // readable words
  // ----------------------------------------
  assign ctrl_word = {11'h000, hwmode_q, scan_q, oneshot_q, start_q, enable_q};
  assign chsel_word = {11'h000, chsel_q};
  assign status_word = {11'h000, busy_o, state_q, idx_q};

  // ----------------------------------------
  // trial code step
  // ----------------------------------------
  // decided bits kept, bit below the trial becomes the next trial
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1) begin : g_trial
      if (gi == 9) begin : g_top
        assign sar_step[gi] = sar_final[gi];
      end else begin : g_rest
        assign sar_step[gi] = sar_final[gi] | bit_mask[gi + 1];
      end
    end
  endgenerate

  // ----------------------------------------
  // comparator synchroniser
  // ----------------------------------------
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      comp_meta_q <= 1'b0;
      comp_s_q <= 1'b0;
    end else begin
      comp_meta_q <= comp_i;
      comp_s_q <= comp_meta_q;
    end
  end

  // ----------------------------------------
  // sequencer next state
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    enable_d = enable_q;
    start_d = start_q;
    oneshot_d = oneshot_q;
    scan_d = scan_q;
    hwmode_d = hwmode_q;
    chsel_d = chsel_q;
    idx_d = idx_q;
    launch = 1'b0;
    store = 1'b0;
    restart = 1'b0;
    irq_d = 1'b0;

    if (wr_ctrl) begin
      enable_d = wr_enable;
      oneshot_d = wr_oneshot;
      scan_d = wr_scan;
      hwmode_d = wr_hwmode;
      // old enable decides, so a combined write cannot start
      if (enable_q) begin
        start_d = wr_start;
      end else begin
        start_d = 1'b0;
      end
      if (abort_start) begin
        restart = 1'b1;
      end
    end

    if (wr_chsel) begin
      chsel_d = wdata_i[4:0];
      if (abort_chsel) begin
        restart = 1'b1;
      end
    end

    if (abort_trig) begin
      restart = 1'b1;
    end

    if (!enable_d) begin
      state_d = ST_STOP;
      start_d = 1'b0;
    end else if (!start_d) begin
      state_d = ST_STBY;
    end else begin
      case (state_q)
        ST_STOP, ST_STBY: begin
          if (hwmode_d) begin
            state_d = ST_HWSTBY;
          end else begin
            launch = 1'b1;
            idx_d = 2'h0;
          end
        end
        ST_HWSTBY: begin
          if (!hwmode_d || (hw_trig_i && hwmode_q)) begin
            launch = 1'b1;
            idx_d = 2'h0;
          end
        end
        ST_CONV: begin
          if (restart) begin
            launch = 1'b1;
            idx_d = 2'h0;
          end else if (done_w) begin
            store = 1'b1;
            irq_d = 1'b1;
            if (scan_q && (idx_q != LAST_SLOT)) begin
              launch = 1'b1;
              idx_d = idx_q + 2'h1;
            end else if (!oneshot_q) begin
              launch = 1'b1;
              idx_d = 2'h0;
            end else if (hwmode_q) begin
              state_d = ST_HWSTBY;
              idx_d = 2'h0;
            end else begin
              start_d = 1'b0;
              state_d = ST_STBY;
              idx_d = 2'h0;
            end
          end
        end
        default: begin
          state_d = ST_STBY;
        end
      endcase
    end

    if (launch) begin
      state_d = ST_CONV;
    end
    // select mode always converts slot zero only
    if (!scan_d) begin
      idx_d = 2'h0;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= ST_STOP;
      enable_q <= 1'b0;
      start_q <= 1'b0;
      oneshot_q <= 1'b0;
      scan_q <= 1'b0;
      hwmode_q <= 1'b0;
      chsel_q <= `ADC_CHSEL_RST;
      idx_q <= 2'h0;
      powered_o <= 1'b0;
      busy_o <= 1'b0;
      conv_end_interrupt_o <= 1'b0;
    end else begin
      state_q <= state_d;
      enable_q <= enable_d;
      start_q <= start_d;
      oneshot_q <= oneshot_d;
      scan_q <= scan_d;
      hwmode_q <= hwmode_d;
      chsel_q <= chsel_d;
      idx_q <= idx_d;
      powered_o <= enable_d;
      busy_o <= (state_d == ST_CONV);
      conv_end_interrupt_o <= irq_d;
    end
  end

  // ----------------------------------------
  // approximation engine
  // ----------------------------------------
  // a launch always reloads, so a partial result is simply dropped
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sample_o <= 1'b0;
      sar_code_o <= 10'h000;
      channel_o <= 5'h00;
      cnt_q <= 8'h00;
      bit_q <= 4'h0;
    end else if (launch) begin
      sample_o <= 1'b1;
      sar_code_o <= 10'h000;
      channel_o <= chan_next;
      cnt_q <= SAMP_LD;
      bit_q <= 4'h9;
    end else if (state_d != ST_CONV) begin
      sample_o <= 1'b0;
      sar_code_o <= 10'h000;
      cnt_q <= 8'h00;
      bit_q <= 4'h0;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end else if (sample_o) begin
      sample_o <= 1'b0;
      sar_code_o <= 10'h200;
      cnt_q <= CMP_LD;
    end else if (bit_q != 4'h0) begin
      sar_code_o <= sar_step;
      bit_q <= bit_q - 4'h1;
      cnt_q <= CMP_LD;
    end
  end

  // ----------------------------------------
  // result registers
  // ----------------------------------------
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      res_full_q <= `ADC_RES_RST;
      res_upper_q <= 8'h00;
    end else if (store) begin
      res_full_q <= {sar_final, 6'h00};
      res_upper_q <= sar_final[9:2];
    end
  end

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  always @* begin
    rdata_d = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        `ADC_OFS_CTRL: begin
          rdata_d = ctrl_word;
        end
        `ADC_OFS_CHSEL: begin
          rdata_d = chsel_word;
        end
        `ADC_OFS_RES_FULL: begin
          rdata_d = res_full_q;
        end
        `ADC_OFS_RES_UPPER: begin
          rdata_d = {8'h00, res_upper_q};
        end
        `ADC_OFS_STATUS: begin
          rdata_d = status_word;
        end
        default: begin
          rdata_d = 16'h0000;
        end
      endcase
    end
  end

  // data stand for one cycle only, zero otherwise
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= rdata_d;
    end
  end

endmodule // adc_conversion_sequencer
